// ### verilog/csc_regs.sv
`include "csc_cfg.svh"
`default_nettype none
module csc_regs #(
  parameter int unsigned TICK_DIV     = `CSC_CLK_HZ,
  parameter int unsigned PCHG_SECONDS = 1800
) (
  input  wire logic       clock,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Analog charger conditions (asynchronous)
  input  wire logic       thermal_reg_in,
  input  wire logic       input_limit_in,
  input  wire logic       temp_out_of_range,
  input  wire logic       sensor_missing,
  input  wire logic       below_term_current,
  input  wire logic       in_precharge,
  input  wire logic       dynamic_timer_slowdown,
  // Charger controls
  output logic            charger_run,
  output logic            charger_hold_reset,
  output logic            thermistor_select
);
  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (TICK_DIV < 2) begin : g_bad_tick_div
    $error("csc_regs: TICK_DIV must be at least 2");
  end
  if (PCHG_SECONDS < 1) begin : g_bad_pchg_seconds
    $error("csc_regs: PCHG_SECONDS must be positive");
  end

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Two flops per pin; only the second stage is read
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  always_ff @(posedge clock) begin
    sync_a <= {thermal_reg_in, input_limit_in, temp_out_of_range, sensor_missing,
               below_term_current, in_precharge, dynamic_timer_slowdown};
    sync_b <= sync_a;
  end
  logic thermal_reg_flag;
  logic input_limit_loop_flag;
  logic temp_suspend_flag;
  logic batt_temp_error_flag;
  logic below_term;
  logic precharge;
  logic dyn_on;
  assign thermal_reg_flag      = sync_b[6];
  assign input_limit_loop_flag = sync_b[5];
  // Suspend and error share one source; no separate window detector here
  assign temp_suspend_flag     = sync_b[4] | sync_b[3];
  assign batt_temp_error_flag  = sync_b[3] | sync_b[4];
  assign below_term            = sync_b[2];
  assign precharge             = sync_b[1];
  assign dyn_on                = sync_b[0];

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  // One decoder serves both the write and the read path
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  logic [7:0] charger_control;
  always_ff @(posedge clock) begin
    if (srst) begin
      charger_control <= `CSC_CONTROL_RESET;
    end else if (reg_wr && addr_hit(reg_addr, `CSC_CONTROL_ADDR)) begin
      charger_control <= reg_wdata;
    end
  end

  logic timers_on;
  logic timer_pause;
  logic charger_on;
  logic restart;
  logic no_term;
  assign timers_on   = charger_control[`CSC_CT_TIMERS_ON];
  assign timer_pause = charger_control[`CSC_CT_PAUSE];
  assign charger_on  = charger_control[`CSC_CT_CHARGER_ON];
  assign restart     = charger_control[`CSC_CT_RESTART];
  assign no_term     = charger_control[`CSC_CT_NO_TERM];
  assign thermistor_select = charger_control[`CSC_CT_THERM_SEL];
  assign charger_hold_reset = restart;

  // Fast-charge limit in timer seconds
  function automatic logic [31:0] fast_limit(input logic [1:0] sel);
    case (csc_pkg::csc_timer_sel_t'(sel))
      csc_pkg::CSC_T4H: fast_limit = 32'(`CSC_HOURS_00 * `CSC_SEC_PER_HOUR);
      csc_pkg::CSC_T5H: fast_limit = 32'(`CSC_HOURS_01 * `CSC_SEC_PER_HOUR);
      csc_pkg::CSC_T6H: fast_limit = 32'(`CSC_HOURS_10 * `CSC_SEC_PER_HOUR);
      default:          fast_limit = 32'(`CSC_HOURS_11 * `CSC_SEC_PER_HOUR);
    endcase
  endfunction

  // ------------------------------------------------------------
  // Charge sequence state
  // ------------------------------------------------------------
  logic term_current_flag;
  logic charge_timeout_flag;
  logic precharge_timeout_flag;
  logic stopped;
  // Any latched termination stops the charger
  assign stopped = term_current_flag | charge_timeout_flag;
  // Restart holds the charger off until the host clears the bit
  assign charger_run = charger_on && !restart && !stopped && !temp_suspend_flag;

  // ------------------------------------------------------------
  // Timer tick and elapsed seconds
  // ------------------------------------------------------------
  logic tick;
  logic count_en;
  assign count_en = charger_run && timers_on && !timer_pause;

  csc_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clock (clock),
    .srst  (srst),
    .run   (count_en),
    .slow  (dyn_on && (thermal_reg_flag || input_limit_loop_flag)),
    .tick  (tick)
  );

  // Pause keeps the count; timers off or restart clears it
  logic [31:0] seconds;
  always_ff @(posedge clock) begin
    if (srst || restart || !charger_on || !timers_on) begin
      seconds <= 32'h0;
    end else if (tick) begin
      seconds <= seconds + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // Termination latches
  // ------------------------------------------------------------
  // Restart and disable clear the latched terminations
  always_ff @(posedge clock) begin
    if (srst || restart || !charger_on) begin
      charge_timeout_flag    <= 1'b0;
      precharge_timeout_flag <= 1'b0;
    end else if (timers_on && charger_run) begin
      if (precharge && seconds >= 32'(PCHG_SECONDS)) begin
        precharge_timeout_flag <= 1'b1;
        charge_timeout_flag    <= 1'b1;
      end else if (seconds >= fast_limit(charger_control[7:6])) begin
        charge_timeout_flag    <= 1'b1;
      end
    end
  end

  // Bit 2 set: no current termination, charger stays on
  always_ff @(posedge clock) begin
    if (srst || restart || !charger_on || no_term) begin
      term_current_flag <= 1'b0;
    end else if (charger_run && !precharge && below_term) begin
      term_current_flag <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Read path; status writes fall through unused
  // ------------------------------------------------------------
  logic [7:0] charger_status;
  always_comb begin
    charger_status = 8'h00;
    charger_status[`CSC_ST_THERMAL_REG]  = thermal_reg_flag && charger_run;
    charger_status[`CSC_ST_INPUT_LIMIT]  = input_limit_loop_flag && charger_run;
    charger_status[`CSC_ST_TEMP_SUSPEND] = temp_suspend_flag && charger_on;
    charger_status[`CSC_ST_TERM_CURRENT] = term_current_flag;
    charger_status[`CSC_ST_ACTIVE]       = charger_run;
    charger_status[`CSC_ST_CHG_TIMEOUT]  = charge_timeout_flag;
    charger_status[`CSC_ST_PCHG_TIMEOUT] = precharge_timeout_flag;
    charger_status[`CSC_ST_BATT_TEMP]    = batt_temp_error_flag;
  end

  // Unmapped addresses read as zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (addr_hit(reg_addr, `CSC_STATUS_ADDR)) begin
      next_rdata = charger_status;
    end else if (addr_hit(reg_addr, `CSC_CONTROL_ADDR)) begin
      next_rdata = charger_control;
    end
  end

  // Read data is registered, so it follows the address by one clock
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // csc_regs
`default_nettype wire

// ### verilog/csc_cfg.svh
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CSC_STATUS_ADDR      8'h03
`define CSC_CONTROL_ADDR     8'h04
`define CSC_CONTROL_RESET    8'hb1

// ------------------------------------------------------------
// Status bit positions
// ------------------------------------------------------------
`define CSC_ST_THERMAL_REG   7
`define CSC_ST_INPUT_LIMIT   6
`define CSC_ST_TEMP_SUSPEND  5
`define CSC_ST_TERM_CURRENT  4
`define CSC_ST_ACTIVE        3
`define CSC_ST_CHG_TIMEOUT   2
`define CSC_ST_PCHG_TIMEOUT  1
`define CSC_ST_BATT_TEMP     0

// ------------------------------------------------------------
// Control bit positions
// ------------------------------------------------------------
`define CSC_CT_TIMER_HI      7
`define CSC_CT_TIMER_LO      6
`define CSC_CT_TIMERS_ON     5
`define CSC_CT_THERM_SEL     4
`define CSC_CT_RESTART       3
`define CSC_CT_NO_TERM       2
`define CSC_CT_PAUSE         1
`define CSC_CT_CHARGER_ON    0

// ------------------------------------------------------------
// Timing (hours, and one timer tick per second)
// ------------------------------------------------------------
`define CSC_HOURS_00         4
`define CSC_HOURS_01         5
`define CSC_HOURS_10         6
`define CSC_HOURS_11         8
`define CSC_SEC_PER_HOUR     3600
`define CSC_CLK_HZ           125000000

`endif

// ### verilog/csc_pkg.sv
`default_nettype none
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_T4H, CSC_T5H, CSC_T6H, CSC_T8H
  } csc_timer_sel_t;
  typedef enum logic {
    CSC_NTC_100K, CSC_NTC_10K
  } csc_ntc_t;
endpackage
`default_nettype wire

// ### verilog/csc_tick.sv
`include "csc_cfg.svh"
`default_nettype none
// ------------------------------------------------------------
// Timer tick prescaler, optionally half rate
// ------------------------------------------------------------
module csc_tick #(
  parameter int unsigned DIV = `CSC_CLK_HZ
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic run,
  input  wire logic slow,
  output logic      tick
);
  if (DIV < 2) begin : g_bad_div
    $error("csc_tick: DIV must be at least 2");
  end

  logic [31:0] count;
  logic        half;

  always_ff @(posedge clock) begin
    if (srst || !run) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count >= DIV - 1) begin
      count <= 32'h0;
      tick  <= !slow || half;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end

  // Every second prescaler wrap is dropped while slowed
  always_ff @(posedge clock) begin
    if (srst) begin
      half <= 1'b0;
    end else if (run && count >= DIV - 1) begin
      half <= slow ? !half : 1'b0;
    end
  end
endmodule // csc_tick
`default_nettype wire

// ### verif/csc_checker.sv
`default_nettype none
// ------------------------------------------------------------
// Port relation checks
// ------------------------------------------------------------
module csc_checker (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       thermal_reg_in,
  input wire logic       temp_out_of_range,
  input wire logic       charger_run,
  input wire logic       charger_hold_reset,
  input wire logic       thermistor_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wire logic wc = reg_wr && reg_addr == 8'h04;
  wire logic rs = reg_addr == 8'h03;
  property p_hold; wc |=> charger_hold_reset == $past(reg_wdata[3]); endproperty
  a_hold: assert property (p_hold) else $error("restart bit wrong");
  property p_ntc; wc |=> thermistor_select == $past(reg_wdata[4]); endproperty
  a_ntc: assert property (p_ntc) else $error("thermistor select wrong");
  property p_off; wc && !reg_wdata[0] |=> !charger_run; endproperty
  a_off: assert property (p_off) else $error("charger not off");
  property p_rst; charger_hold_reset |-> !charger_run; endproperty
  a_rst: assert property (p_rst) else $error("charger runs in reset");
  property p_ro;
    reg_wr && rs |=> $stable(thermistor_select) && $stable(charger_hold_reset);
  endproperty
  a_ro: assert property (p_ro) else $error("status write had effect");
  property p_act; $past(rs) && $past(!srst) |-> reg_rdata[3] == $past(charger_run); endproperty
  a_act: assert property (p_act) else $error("active bit wrong");
  property p_thermal_reg_flag; (rs && thermal_reg_in && charger_run)[*4] |=> reg_rdata[7]; endproperty
  a_thermal_reg_flag: assert property (p_thermal_reg_flag) else $error("thermal bit missing");
  property p_bt; (rs && temp_out_of_range)[*4] |=> reg_rdata[0]; endproperty
  a_bt: assert property (p_bt) else $error("temperature bit missing");
  c_hold: cover property (charger_hold_reset[*2]);
  c_tout: cover property (rs ##1 reg_rdata[1]);
  c_ro: cover property (reg_wr && rs);
endmodule // csc_checker
`default_nettype wire

// ### verif/csc_host_model.sv
`default_nettype none
// ------------------------------------------------------------
// Host side of the register port
// ------------------------------------------------------------
module csc_host_model (
  input  wire logic       clock,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_wr    = 1'b1;
    reg_wdata = v;
    @(posedge clock);
    #1;
    reg_wr    = 1'b0;
    // Stale data inverted so it never looks valid
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    #1;
    reg_addr = a;
    @(posedge clock);
    #1;
    v = reg_rdata;
  endtask
  task automatic restart(input logic [7:0] c);
    wr(8'h04, c | 8'h08);
    wr(8'h04, c & 8'hf7);
  endtask
endmodule // csc_host_model
`default_nettype wire

// ### verif/test_charger_status_control_regs.sv
`default_nettype none
module test_charger_status_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus and checking
  // ------------------------------------------------------------
  logic       clock, srst, reg_wr, charger_run, charger_hold_reset, thermistor_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, v;
  logic [6:0] cond;
  int         bad_count, total_checks, seed, n1, n2;
  logic [7:0] expv [4] = '{8'h88, 8'h48, 8'h21, 8'h21};
  csc_regs #(.TICK_DIV(8), .PCHG_SECONDS(3)) csc_regs_inst (
    .clock, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .thermal_reg_in(cond[6]), .input_limit_in(cond[5]), .temp_out_of_range(cond[4]),
    .sensor_missing(cond[3]), .below_term_current(cond[2]), .in_precharge(cond[1]),
    .dynamic_timer_slowdown(cond[0]), .charger_run, .charger_hold_reset, .thermistor_select);
  csc_host_model csc_host_model_inst (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata);
  task automatic rd(input logic [7:0] a);
    csc_host_model_inst.rd(a, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    csc_host_model_inst.wr(a, b);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Status from the rules with the charger enabled and nothing latched
  function automatic logic [7:0] model_status(input logic [6:0] c);
    logic temp;
    logic run;
    temp = c[4] | c[3];
    run  = !temp;
    model_status = {c[6] & run, c[5] & run, temp, 1'b0, run, 2'b00, temp};
  endfunction
  task tally_and_finish;
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Polls status until the precharge timeout shows, bounded
  task automatic waitst(output int c);
    c = 0;
    do begin
      rd(8'h03);
      c++;
    end while (d[1] !== 1'b1 && c < 300);
    if (c >= 300) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    seed = 40158;
    srst = 1'b1;
    cond = 7'h00;
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    rd(8'h04);
    chk(d, 8'hb1);
    rd(8'h03);
    chk(d, 8'h08);
    rd(8'h10);
    chk(d, 8'h00);
    wr(8'h03, 8'hff);
    rd(8'h04);
    chk(d, 8'hb1);
    repeat (8) begin
      v = $random(seed);
      wr(8'h04, v);
      rd(8'h04);
      chk(d, v);
      chk({6'h00, charger_hold_reset, thermistor_select}, {6'h00, v[3], v[4]});
      if (!v[0]) chk({7'h00, charger_run}, 8'h00);
    end
    csc_host_model_inst.restart(8'hb1);
    rd(8'h03);
    for (int i = 0; i < 4; i++) begin
      cond = 7'h40 >> i;
      repeat (4) @(posedge clock);
      rd(8'h03);
      chk(d, expv[i]);
    end
    // Random conditions; termination and precharge inputs kept low
    repeat (8) begin
      cond = 7'($random(seed)) & 7'h79;
      repeat (4) @(posedge clock);
      rd(8'h03);
      chk(d, model_status(cond));
    end
    cond = 7'h04;
    repeat (4) @(posedge clock);
    rd(8'h03);
    chk(d, 8'h10);
    cond = 7'h00;
    csc_host_model_inst.restart(8'hb5);
    cond = 7'h04;
    repeat (4) @(posedge clock);
    rd(8'h03);
    chk(d, 8'h08);
    cond = 7'h00;
    csc_host_model_inst.restart(8'hb1);
    cond = 7'h02;
    waitst(n1);
    chk(d, 8'h06);
    cond = 7'h00;
    csc_host_model_inst.restart(8'hb3);
    cond = 7'h02;
    repeat (100) @(posedge clock);
    rd(8'h03);
    chk(d, 8'h08);
    wr(8'h04, 8'h91);
    repeat (100) @(posedge clock);
    rd(8'h03);
    chk(d, 8'h08);
    cond = 7'h00;
    wr(8'h04, 8'hb1);
    cond = 7'h43;
    waitst(n2);
    chk({7'h00, n2 > n1 + n1 / 2}, 8'h01);
    // Reset in mid-run clears the latched timeouts
    cond = 7'h00;
    srst = 1'b1;
    repeat (2) @(posedge clock);
    #1 srst = 1'b0;
    rd(8'h04);
    chk(d, 8'hb1);
    rd(8'h03);
    chk(d, 8'h08);
    tally_and_finish();
  end
endmodule // test_charger_status_control_regs
bind csc_regs csc_checker csc_checker_inst (
  .clock              (clock),
  .srst               (srst),
  .reg_addr           (reg_addr),
  .reg_wr             (reg_wr),
  .reg_wdata          (reg_wdata),
  .reg_rdata          (reg_rdata),
  .thermal_reg_in     (thermal_reg_in),
  .temp_out_of_range  (temp_out_of_range),
  .charger_run        (charger_run),
  .charger_hold_reset (charger_hold_reset),
  .thermistor_select  (thermistor_select)
);
`default_nettype wire
